/* dmr_pkg.sv */
package dmr_pkg;
	localparam int SAMPLE_W = 24;
	localparam int ADDR_W = 8;
	localparam int REG_W = 16;
	localparam int COEF_FRAC = 15;

	// register offsets
	localparam logic [7:0] OFS_AUDIO_PORT_ROUTING_CTRL = 8'h18;
	localparam logic [7:0] OFS_SIDETONE_MIX_CTRL = 8'h20;
	localparam logic [7:0] OFS_MIC_POLARITY_CTRL = 8'h26;
	localparam logic [7:0] OFS_MIX_MODE_CTRL = 8'h30;
	localparam logic [7:0] OFS_MIX_STATUS = 8'h32;

	// audio_port_routing_ctrl fields
	localparam int BIT_LEFT_RX_INVERT = 12;
	localparam int BIT_RIGHT_RX_INVERT = 11;
	localparam int BIT_BOOST_LO = 9;
	localparam int BIT_LEFT_TX_SLOT_SOURCE = 7;
	localparam int BIT_RIGHT_TX_SLOT_SOURCE = 6;
	localparam int BIT_LEFT_DAC_RX_SOURCE = 5;
	localparam int BIT_RIGHT_DAC_RX_SOURCE = 4;
	localparam logic [15:0] ROUTING_MASK = 16'h1ef0;
	localparam logic [15:0] ROUTING_RESET = 16'h0050;

	// sidetone_mix_ctrl fields
	localparam int BIT_LEFT_SIDETONE_VOLUME_LO = 8;
	localparam int BIT_RIGHT_SIDETONE_VOLUME_LO = 4;
	localparam int BIT_LEFT_SIDETONE_SOURCE_LO = 2;
	localparam int BIT_RIGHT_SIDETONE_SOURCE_LO = 0;
	localparam logic [15:0] SIDETONE_MASK = 16'h0fff;
	localparam logic [15:0] SIDETONE_RESET = 16'h0000;

	// mic_polarity_ctrl fields
	localparam int BIT_LEFT_MIC_INVERT = 1;
	localparam int BIT_RIGHT_MIC_INVERT = 0;
	localparam logic [15:0] MIC_POL_MASK = 16'h0003;
	localparam logic [15:0] MIC_POL_RESET = 16'h0000;

	// mix_mode_ctrl fields
	localparam int BIT_MONO_MIX = 0;
	localparam int BIT_DRC_IN_DAC_PATH = 1;
	localparam logic [15:0] MIX_MODE_MASK = 16'h0003;
	localparam logic [15:0] MIX_MODE_RESET = 16'h0000;

	// mix_status fields, write one to clear
	localparam int BIT_LEFT_CLIP = 0;
	localparam int BIT_RIGHT_CLIP = 1;

	typedef enum logic [1:0] {
		DMR_ST_NONE = 2'b00,
		DMR_ST_LEFT = 2'b01,
		DMR_ST_RIGHT = 2'b10,
		DMR_ST_RSVD = 2'b11
	} dmr_st_src_t;

	// sidetone gain, unsigned with 1.0 = 0x8000, 3 dB per code from -36 dB
	function automatic logic [15:0] dmr_st_coef(input logic [3:0] code);
		logic [15:0] c;
		c = 16'h8000;
		case (code)
			4'h0: c = 16'h0207;
			4'h1: c = 16'h02de;
			4'h2: c = 16'h040c;
			4'h3: c = 16'h05b8;
			4'h4: c = 16'h0814;
			4'h5: c = 16'h0b69;
			4'h6: c = 16'h101d;
			4'h7: c = 16'h16c3;
			4'h8: c = 16'h2027;
			4'h9: c = 16'h2d6b;
			4'ha: c = 16'h4027;
			4'hb: c = 16'h5a9e;
			default: c = 16'h8000;
		endcase
		return c;
	endfunction
endpackage

/* dmr_sidetone_scale.sv */
module dmr_sidetone_scale #(
	parameter int DW = dmr_pkg::SAMPLE_W
) (
	// filtered microphone samples
	input wire logic signed [DW-1:0] mic_l_i,
	input wire logic signed [DW-1:0] mic_r_i,
	// controls
	input wire logic [1:0] src_i,
	input wire logic [3:0] vol_i,
	// scaled sidetone
	output logic signed [DW-1:0] st_o
);
	import dmr_pkg::*;

	logic signed [DW-1:0] sel;
	logic signed [DW+16:0] prod;
	logic signed [DW+16:0] shifted;

	always_comb begin
		unique case (dmr_st_src_t'(src_i))
			DMR_ST_LEFT: sel = mic_l_i;
			DMR_ST_RIGHT: sel = mic_r_i;
			DMR_ST_NONE, DMR_ST_RSVD: sel = '0;
		endcase
		prod = sel * $signed({1'b0, dmr_st_coef(vol_i)});
		shifted = prod >>> COEF_FRAC;
		// gain never exceeds 1.0 so the low bits always hold the result
		st_o = shifted[DW-1:0];
	end
endmodule

/* dmr_chan_mix.sv */
module dmr_chan_mix #(
	parameter int DW = dmr_pkg::SAMPLE_W
) (
	// routed receive data and sidetone
	input wire logic signed [DW-1:0] rx_i,
	input wire logic signed [DW-1:0] st_i,
	input wire logic [1:0] boost_i,
	// dac input word
	output logic signed [DW-1:0] dac_o,
	output logic clip_o
);
	localparam logic signed [DW+4:0] MAXV = (DW+5)'((64'sd1 <<< (DW-1)) - 1);
	localparam logic signed [DW+4:0] MINV = -MAXV - (DW+5)'(1);

	logic signed [DW+4:0] boosted;
	logic signed [DW+4:0] sum;

	always_comb begin
		// 6 dB per boost step
		boosted = (DW+5)'(rx_i) <<< boost_i;
		sum = boosted + (DW+5)'(st_i);
		clip_o = 1'b0;
		dac_o = sum[DW-1:0];
		if (sum > MAXV) begin
			dac_o = MAXV[DW-1:0];
			clip_o = 1'b1;
		end else if (sum < MINV) begin
			dac_o = MINV[DW-1:0];
			clip_o = 1'b1;
		end
	end
endmodule

/* dmr_mix_router.sv */
// Function
// - left tx slot source select, reset 0
// - right tx slot source select, reset 1
// - mic polarity inversion per channel
// - dac data inversion per channel
// - left dac receive source select
// - right dac receive source select, reset 1
// - receive boost 0/6/12/18 dB
// - sidetone taken from filtered mic data
// - left dac sidetone source field
// - right dac sidetone source field
// - four-bit sidetone volume per dac
// - volume -36 dB, 3 dB steps, 0 dB top
// - add scaled sidetone to dac data
// - optional mono mix to both dacs
// - dynamic range control path select
module dmr_mix_router #(
	parameter int DW = dmr_pkg::SAMPLE_W
) (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	// register port
	input wire logic [dmr_pkg::ADDR_W-1:0] REG_ADDR_I,
	input wire logic [dmr_pkg::REG_W-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [dmr_pkg::REG_W-1:0] REG_RDATA_O,
	// microphone high-pass filter outputs
	input wire logic signed [DW-1:0] MIC_L_I,
	input wire logic signed [DW-1:0] MIC_R_I,
	input wire logic MIC_VALID_I,
	// interface receive words
	input wire logic signed [DW-1:0] RX_L_I,
	input wire logic signed [DW-1:0] RX_R_I,
	input wire logic RX_VALID_I,
	// interface transmit slots
	output logic signed [DW-1:0] TX_L_O,
	output logic signed [DW-1:0] TX_R_O,
	output logic TX_VALID_O,
	// dac inputs
	output logic signed [DW-1:0] DAC_L_O,
	output logic signed [DW-1:0] DAC_R_O,
	output logic DAC_VALID_O,
	// dynamic range control placement
	output logic DRC_IN_DAC_PATH_O
);
	import dmr_pkg::*;

	localparam logic signed [DW-1:0] SMAX = {1'b0, {(DW-1){1'b1}}};
	localparam logic signed [DW-1:0] SMIN = {1'b1, {(DW-1){1'b0}}};

	function automatic logic signed [DW-1:0] neg_sat(input logic signed [DW-1:0] x,
			input logic inv);
		logic signed [DW-1:0] r;
		r = x;
		if (inv) begin
			r = (x == SMIN) ? SMAX : -x;
		end
		return r;
	endfunction

	// register state
	logic [15:0] routing_ff, nxt_routing;
	logic [15:0] sidetone_ff, nxt_sidetone;
	logic [15:0] mic_pol_ff, nxt_mic_pol;
	logic [15:0] mix_mode_ff, nxt_mix_mode;
	logic [1:0] clip_ff, nxt_clip;
	logic [15:0] rdata_ff, nxt_rdata;
	logic drc_ff, nxt_drc;

	// datapath state
	logic signed [DW-1:0] mic_l_ff, nxt_mic_l;
	logic signed [DW-1:0] mic_r_ff, nxt_mic_r;
	logic signed [DW-1:0] tx_l_ff, nxt_tx_l;
	logic signed [DW-1:0] tx_r_ff, nxt_tx_r;
	logic tx_vld_ff, nxt_tx_vld;
	logic signed [DW-1:0] dac_l_ff, nxt_dac_l;
	logic signed [DW-1:0] dac_r_ff, nxt_dac_r;
	logic dac_vld_ff, nxt_dac_vld;

	logic signed [DW-1:0] mic_l_pol, mic_r_pol;
	logic signed [DW-1:0] rx_l_sel, rx_r_sel;
	logic signed [DW:0] mono_sum;
	logic signed [DW-1:0] mix_l, mix_r;
	logic signed [DW-1:0] st_l, st_r;
	logic signed [DW-1:0] ch_l, ch_r;
	logic clip_l, clip_r;

	// configuration registers
	always_comb begin
		nxt_routing = routing_ff;
		nxt_sidetone = sidetone_ff;
		nxt_mic_pol = mic_pol_ff;
		nxt_mix_mode = mix_mode_ff;
		if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				OFS_AUDIO_PORT_ROUTING_CTRL: nxt_routing = REG_WDATA_I & ROUTING_MASK;
				OFS_SIDETONE_MIX_CTRL: nxt_sidetone = REG_WDATA_I & SIDETONE_MASK;
				OFS_MIC_POLARITY_CTRL: nxt_mic_pol = REG_WDATA_I & MIC_POL_MASK;
				OFS_MIX_MODE_CTRL: nxt_mix_mode = REG_WDATA_I & MIX_MODE_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			routing_ff <= ROUTING_RESET;
			sidetone_ff <= SIDETONE_RESET;
			mic_pol_ff <= MIC_POL_RESET;
			mix_mode_ff <= MIX_MODE_RESET;
		end else begin
			routing_ff <= nxt_routing;
			sidetone_ff <= nxt_sidetone;
			mic_pol_ff <= nxt_mic_pol;
			mix_mode_ff <= nxt_mix_mode;
		end
	end

	// sticky clip flags, write one to clear
	always_comb begin
		nxt_clip = clip_ff;
		if (REG_WR_I && REG_ADDR_I == OFS_MIX_STATUS) begin
			nxt_clip = clip_ff & ~REG_WDATA_I[1:0];
		end
		// a clip in the clearing cycle stays recorded
		if (RX_VALID_I) begin
			nxt_clip = nxt_clip | {clip_r, clip_l};
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			clip_ff <= 2'b00;
		end else begin
			clip_ff <= nxt_clip;
		end
	end

	// read data stands one cycle and is zero otherwise
	always_comb begin
		nxt_rdata = '0;
		if (REG_RD_I) begin
			unique case (REG_ADDR_I)
				OFS_AUDIO_PORT_ROUTING_CTRL: nxt_rdata = routing_ff;
				OFS_SIDETONE_MIX_CTRL: nxt_rdata = sidetone_ff;
				OFS_MIC_POLARITY_CTRL: nxt_rdata = mic_pol_ff;
				OFS_MIX_MODE_CTRL: nxt_rdata = mix_mode_ff;
				OFS_MIX_STATUS: nxt_rdata = {14'h0000, clip_ff};
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// range controller placement, registered so the output comes from a flop
	always_comb begin
		nxt_drc = mix_mode_ff[BIT_DRC_IN_DAC_PATH];
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			drc_ff <= 1'b0;
		end else begin
			drc_ff <= nxt_drc;
		end
	end

	// microphone side: polarity, slot routing, sidetone hold
	always_comb begin
		mic_l_pol = neg_sat(MIC_L_I, mic_pol_ff[BIT_LEFT_MIC_INVERT]);
		mic_r_pol = neg_sat(MIC_R_I, mic_pol_ff[BIT_RIGHT_MIC_INVERT]);
		nxt_tx_l = tx_l_ff;
		nxt_tx_r = tx_r_ff;
		nxt_mic_l = mic_l_ff;
		nxt_mic_r = mic_r_ff;
		nxt_tx_vld = MIC_VALID_I;
		if (MIC_VALID_I) begin
			nxt_tx_l = routing_ff[BIT_LEFT_TX_SLOT_SOURCE] ? mic_r_pol : mic_l_pol;
			nxt_tx_r = routing_ff[BIT_RIGHT_TX_SLOT_SOURCE] ? mic_r_pol : mic_l_pol;
			// held so sidetone is ready whenever a receive word arrives
			nxt_mic_l = MIC_L_I;
			nxt_mic_r = MIC_R_I;
		end
	end

	// receive side: routing, inversion, mono mix
	always_comb begin
		rx_l_sel = routing_ff[BIT_LEFT_DAC_RX_SOURCE] ? RX_R_I : RX_L_I;
		rx_r_sel = routing_ff[BIT_RIGHT_DAC_RX_SOURCE] ? RX_R_I : RX_L_I;
		rx_l_sel = neg_sat(rx_l_sel, routing_ff[BIT_LEFT_RX_INVERT]);
		rx_r_sel = neg_sat(rx_r_sel, routing_ff[BIT_RIGHT_RX_INVERT]);
		mono_sum = (DW+1)'(rx_l_sel) + (DW+1)'(rx_r_sel);
		mix_l = rx_l_sel;
		mix_r = rx_r_sel;
		if (mix_mode_ff[BIT_MONO_MIX]) begin
			// halving keeps the mono word in range without saturation
			mix_l = mono_sum[DW:1];
			mix_r = mono_sum[DW:1];
		end
		nxt_dac_vld = RX_VALID_I;
		nxt_dac_l = RX_VALID_I ? ch_l : dac_l_ff;
		nxt_dac_r = RX_VALID_I ? ch_r : dac_r_ff;
	end

	dmr_sidetone_scale #(.DW(DW)) u_st_l (
		.mic_l_i(mic_l_ff),
		.mic_r_i(mic_r_ff),
		.src_i(sidetone_ff[BIT_LEFT_SIDETONE_SOURCE_LO +: 2]),
		.vol_i(sidetone_ff[BIT_LEFT_SIDETONE_VOLUME_LO +: 4]),
		.st_o(st_l)
	);

	dmr_sidetone_scale #(.DW(DW)) u_st_r (
		.mic_l_i(mic_l_ff),
		.mic_r_i(mic_r_ff),
		.src_i(sidetone_ff[BIT_RIGHT_SIDETONE_SOURCE_LO +: 2]),
		.vol_i(sidetone_ff[BIT_RIGHT_SIDETONE_VOLUME_LO +: 4]),
		.st_o(st_r)
	);

	dmr_chan_mix #(.DW(DW)) u_mix_l (
		.rx_i(mix_l),
		.st_i(st_l),
		.boost_i(routing_ff[BIT_BOOST_LO +: 2]),
		.dac_o(ch_l),
		.clip_o(clip_l)
	);

	dmr_chan_mix #(.DW(DW)) u_mix_r (
		.rx_i(mix_r),
		.st_i(st_r),
		.boost_i(routing_ff[BIT_BOOST_LO +: 2]),
		.dac_o(ch_r),
		.clip_o(clip_r)
	);

	// microphone side registers
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mic_l_ff <= '0;
			mic_r_ff <= '0;
			tx_l_ff <= '0;
			tx_r_ff <= '0;
			tx_vld_ff <= 1'b0;
		end else begin
			mic_l_ff <= nxt_mic_l;
			mic_r_ff <= nxt_mic_r;
			tx_l_ff <= nxt_tx_l;
			tx_r_ff <= nxt_tx_r;
			tx_vld_ff <= nxt_tx_vld;
		end
	end

	// receive side registers
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			dac_l_ff <= '0;
			dac_r_ff <= '0;
			dac_vld_ff <= 1'b0;
		end else begin
			dac_l_ff <= nxt_dac_l;
			dac_r_ff <= nxt_dac_r;
			dac_vld_ff <= nxt_dac_vld;
		end
	end

	assign REG_RDATA_O = rdata_ff;
	assign TX_L_O = tx_l_ff;
	assign TX_R_O = tx_r_ff;
	assign TX_VALID_O = tx_vld_ff;
	assign DAC_L_O = dac_l_ff;
	assign DAC_R_O = dac_r_ff;
	assign DAC_VALID_O = dac_vld_ff;
	assign DRC_IN_DAC_PATH_O = drc_ff;
endmodule

/* dmr_mix_router_props.sv */
module dmr_mix_router_chk
	import dmr_pkg::*;
#(
	parameter int DW = SAMPLE_W
) (
	// clock, reset and register port
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [REG_W-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [REG_W-1:0] REG_RDATA_O,
	// streams
	input wire logic MIC_VALID_I,
	input wire logic RX_VALID_I,
	input wire logic signed [DW-1:0] TX_L_O,
	input wire logic signed [DW-1:0] TX_R_O,
	input wire logic TX_VALID_O,
	input wire logic signed [DW-1:0] DAC_L_O,
	input wire logic signed [DW-1:0] DAC_R_O,
	input wire logic DAC_VALID_O,
	input wire logic DRC_IN_DAC_PATH_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_mode_wr(b);
		REG_WR_I && REG_ADDR_I == OFS_MIX_MODE_CTRL && REG_WDATA_I[1] == b;
	endsequence
	sequence s_rd(a);
		REG_RD_I && REG_ADDR_I == a;
	endsequence
	AST_TX_VALID: assert property (MIC_VALID_I |=> TX_VALID_O)
		else $error("transmit valid missing");
	AST_TX_HOLD: assert property (!MIC_VALID_I |=>
		!TX_VALID_O && $stable(TX_L_O) && $stable(TX_R_O)) else $error("transmit moved");
	AST_DAC_VALID: assert property (RX_VALID_I |=> DAC_VALID_O)
		else $error("dac valid missing");
	AST_DAC_HOLD: assert property (!RX_VALID_I |=>
		!DAC_VALID_O && $stable(DAC_L_O) && $stable(DAC_R_O)) else $error("dac moved");
	AST_RD_IDLE: assert property (!REG_RD_I |=> REG_RDATA_O == 16'h0000)
		else $error("read data not idle");
	AST_RD_POL: assert property (s_rd(OFS_MIC_POLARITY_CTRL) |=> REG_RDATA_O[15:2] == 0)
		else $error("polarity spare bits set");
	AST_RD_ROUTE: assert property (s_rd(OFS_AUDIO_PORT_ROUTING_CTRL) |=>
		(REG_RDATA_O & 16'he10f) == 16'h0000) else $error("routing spare bits set");
	AST_MODE_SET: assert property (s_mode_wr(1'b1) |-> ##[1:2] DRC_IN_DAC_PATH_O)
		else $error("path select not set");
	AST_MODE_CLR: assert property (s_mode_wr(1'b0) |-> ##[1:2] !DRC_IN_DAC_PATH_O)
		else $error("path select not cleared");
endmodule

bind dmr_mix_router dmr_mix_router_chk #(.DW(DW)) i_dmr_mix_router_chk (.REF_CLK_I, .RST_I,
	.REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .MIC_VALID_I, .RX_VALID_I,
	.TX_L_O, .TX_R_O, .TX_VALID_O, .DAC_L_O, .DAC_R_O, .DAC_VALID_O, .DRC_IN_DAC_PATH_O);

/* dmr_host_model.sv */
module dmr_host_model
	import dmr_pkg::*;
(
	// receive words towards the block
	input wire logic clk_i,
	output logic signed [SAMPLE_W-1:0] rx_l_o,
	output logic signed [SAMPLE_W-1:0] rx_r_o,
	output logic rx_valid_o,
	// transmit slots from the block
	input wire logic signed [SAMPLE_W-1:0] tx_l_i,
	input wire logic signed [SAMPLE_W-1:0] tx_r_i,
	input wire logic tx_valid_i,
	output logic signed [SAMPLE_W-1:0] got_l_o,
	output logic signed [SAMPLE_W-1:0] got_r_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_l_o = '0;
		rx_r_o = '0;
		rx_valid_o = 1'b0;
		got_l_o = '0;
		got_r_o = '0;
	end
	always @(posedge clk_i) begin
		if (tx_valid_i) begin
			got_l_o <= tx_l_i;
			got_r_o <= tx_r_i;
		end
	end
	// words stay under full scale for the boost in use, unless a test asks otherwise
	task automatic send(input logic signed [SAMPLE_W-1:0] l, r, input int gap);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		rx_l_o <= l;
		rx_r_o <= r;
		rx_valid_o <= 1'b1;
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		// stale words are not left on the lines, so a late capture shows up
		rx_l_o <= ~l;
		rx_r_o <= ~r;
	endtask
endmodule

/* dmr_mix_router_tb.sv */
module dmr_mix_router_tb
	import dmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd, mv, rv, tv, dv, range_ctl;
	logic [7:0] addr;
	logic [15:0] wd, rdat;
	logic signed [SAMPLE_W-1:0] ml, mr, rl, rr, tl, tr, dl, dr, gl, gr;
	int n_errors = 0;
	int total_checks = 0;
	dmr_mix_router i_dmr_mix_router (.REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr),
		.REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .MIC_L_I(ml),
		.MIC_R_I(mr), .MIC_VALID_I(mv), .RX_L_I(rl), .RX_R_I(rr), .RX_VALID_I(rv),
		.TX_L_O(tl), .TX_R_O(tr), .TX_VALID_O(tv), .DAC_L_O(dl), .DAC_R_O(dr),
		.DAC_VALID_O(dv), .DRC_IN_DAC_PATH_O(range_ctl));
	dmr_host_model i_dmr_host_model (.clk_i(clk), .rx_l_o(rl), .rx_r_o(rr), .rx_valid_o(rv),
		.tx_l_i(tl), .tx_r_i(tr), .tx_valid_i(tv), .got_l_o(gl), .got_r_o(gr));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [SAMPLE_W-1:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk({8'h00, rdat}, {8'h00, e});
	endtask
	task automatic txc(input logic signed [SAMPLE_W-1:0] l, r, el, er);
		@(posedge clk);
		mv <= 1'b1;
		ml <= l;
		mr <= r;
		@(posedge clk);
		mv <= 1'b0;
		ml <= ~l;
		mr <= ~r;
		@(posedge clk);
		#1 chk(gl, el);
		chk(gr, er);
	endtask
	task automatic dac(input logic signed [SAMPLE_W-1:0] l, r, el, er, input int g);
		i_dmr_host_model.send(l, r, g);
		#1 chk(dl, el);
		chk(dr, er);
		chk({23'h0, dv}, 24'h00_0001);
	endtask
	task automatic t_regs();
		rdc(8'h18, 16'h0050);
		rdc(8'h20, 16'h0000);
		wrr(8'h26, 16'hffff);
		rdc(8'h26, 16'h0003);
		wrr(8'h44, 16'hffff);
		rdc(8'h44, 16'h0000);
		wrr(8'h26, 16'h0000);
	endtask
	task automatic t_tx();
		txc(24'h00_0005, 24'h00_0007, 24'h00_0005, 24'h00_0007);
		wrr(8'h18, 16'h0090);
		txc(24'h00_0005, 24'h00_0007, 24'h00_0007, 24'h00_0005);
		wrr(8'h26, 16'h0003);
		txc(24'h80_0000, 24'h00_0009, 24'hff_fff7, 24'h7f_ffff);
		wrr(8'h26, 16'h0000);
		wrr(8'h18, 16'h0050);
	endtask
	task automatic t_rx();
		dac(24'h00_0100, 24'h00_0200, 24'h00_0100, 24'h00_0200, 0);
		wrr(8'h18, 16'h0020);
		dac(24'h00_0100, 24'h00_0200, 24'h00_0200, 24'h00_0100, 2);
		wrr(8'h18, 16'h1a50);
		dac(24'h00_0100, 24'h00_0200, 24'hff_fe00, 24'hff_fc00, 0);
		for (int b = 0; b < 4; b++) begin
			wrr(8'h18, 16'h0050 | (16'(b) << 9));
			dac(24'h00_0010, 24'h00_0010, 24'h10 << b, 24'h10 << b, b);
		end
		dac(24'h20_0000, 24'he0_0000, 24'h7f_ffff, 24'h80_0000, 0);
		rdc(8'h32, 16'h0003);
		wrr(8'h32, 16'h0003);
		rdc(8'h32, 16'h0000);
		wrr(8'h18, 16'h0050);
	endtask
	task automatic t_st();
		// mic samples flow before sidetone is mixed
		txc(24'h00_8000, 24'h00_1000, 24'h00_8000, 24'h00_1000);
		wrr(8'h20, 16'h0d06);
		dac(24'h00_0010, 24'h00_0010, 24'h00_8010, 24'h00_0050, 1);
		wrr(8'h20, 16'h0d0f);
		dac(24'h00_0010, 24'h00_0010, 24'h00_0010, 24'h00_0010, 0);
		wrr(8'h20, 16'h0000);
	endtask
	task automatic t_mode();
		wrr(8'h30, 16'h0001);
		dac(24'h00_0010, 24'h00_0030, 24'h00_0020, 24'h00_0020, 0);
		wrr(8'h30, 16'h0002);
		repeat (2) @(posedge clk);
		#1 chk({23'h0, range_ctl}, 24'h00_0001);
		wrr(8'h30, 16'h0000);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		n_errors++;
		print_verdict();
	end
	initial begin
		{rst, wr, rd, mv} = 4'b1000;
		addr = '0;
		wd = '0;
		ml = '0;
		mr = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// charge pump mode lies outside this block
		t_regs();
		t_tx();
		t_rx();
		t_st();
		t_mode();
		print_verdict();
	end
endmodule
